// File: bench/fom_source.sv
`default_nettype none
module fom_source (
   input  wire logic       clock_i,  // register clock
   input  wire logic       rst_n_i,  // async reset, active low
   input  wire logic       busy_i,   // adaptation running
   input  wire logic [3:0] delay_i,  // cycles per measurement minus one, at least 2
   output logic            valid_o,  // result pulse
   output logic [7:0]      fom_o     // figure of merit
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_q;
   // every result ties, so the starting set must win
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_q <= 4'h0;
         valid_o <= 1'b0;
         fom_o <= 8'h00;
      end else if (busy_i && cnt_q == delay_i) begin
         cnt_q <= 4'h0;
         valid_o <= 1'b1;
         fom_o <= 8'h40;
      end else begin
         cnt_q <= busy_i ? cnt_q + 4'h1 : 4'h0;
         valid_o <= 1'b0;
         fom_o <= ~fom_o; // stale data never holds still
      end
   end
endmodule : fom_source
`default_nettype wire

// File: bench/tb_top.sv
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import retimer_ctrl_pkg::*;
   logic clock_i = 1'b0;
   logic rst_n_i, reg_wr_i, reg_rd_i, signal_detect_i, cdr_locked_i, fom_valid_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, fom_i, rdv;
   logic [1:0] cdr_eye_range_i, eye_range_o;
   tap_set_s taps_o;
   logic dfe_power_down_o, eom_power_down_o, slow_edge_o, invert_o, cdr_reset_o, adapt_busy_o;
   logic [3:0] ctle_boost_o, fom_delay;
   logic [8:0] eye_span_mv_o;
   int errors = 0;
   int tests_run = 0;
   always #25 clock_i = ~clock_i;
   dfe_override_output_ctrl u_dfe_override_output_ctrl (.clock_i, .rst_n_i, .reg_wr_i,
      .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .signal_detect_i, .cdr_locked_i,
      .cdr_eye_range_i, .fom_valid_i, .fom_i, .taps_o, .dfe_power_down_o, .ctle_boost_o,
      .eye_range_o, .eye_span_mv_o, .eom_power_down_o, .slow_edge_o, .invert_o,
      .cdr_reset_o, .adapt_busy_o);
   fom_source u_fom_source (.clock_i, .rst_n_i, .busy_i(adapt_busy_o), .delay_i(fom_delay),
      .valid_o(fom_valid_i), .fom_o(fom_i));
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge clock_i);
      reg_wr_i = 1'b0;
   endtask : wr
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock_i);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge clock_i);
      reg_rd_i = 1'b0;
      rdv = reg_rdata_o;
      chk({8'h0, rdv}, {8'h0, e});
   endtask : rc
   task automatic wait_idle;
      int n;
      n = 0;
      while (adapt_busy_o !== 1'b0 && n < 400) begin
         @(negedge clock_i);
         n++;
      end
      if (adapt_busy_o !== 1'b0) begin
         errors++;
         end_sim;
      end
   endtask : wait_idle
   task automatic t_reset;
      rc(OFS_EYE_SIGNS, 8'h20);
      rc(OFS_TAP1, 8'h00);
      rc(OFS_MANUAL, 8'h00);
      rc(OFS_SLEW, 8'h00);
      rc(OFS_EQ_POWER, 8'h08);
      rc(OFS_OVERRIDE, 8'h40);
      rc(8'h40, 8'h00);
      chk({15'h0, dfe_power_down_o}, 16'h1);
      chk({15'h0, eom_power_down_o}, 16'h1);
      $display("reset test done");
   endtask : t_reset
   task automatic t_range;
      wr(OFS_RANGE_SRC, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(OFS_EYE_SIGNS, {c[1:0], 6'h20});
         @(negedge clock_i);
         chk({14'h0, eye_range_o}, 16'(c));
         chk({7'h0, eye_span_mv_o}, 16'(100 * (c + 1)));
      end
      wr(OFS_EYE_SIGNS, 8'h20);
      wr(OFS_RANGE_SRC, 8'h40);
      repeat (2) @(negedge clock_i);
      chk({14'h0, eye_range_o}, 16'h3);
      $display("range test done");
   endtask : t_range
   task automatic t_manual;
      wr(OFS_MANUAL, 8'h80);
      wr(OFS_EQ_POWER, 8'h00);
      wr(OFS_TAP1, 8'h9f);
      wr(OFS_TAPS23, 8'h21);
      wr(OFS_TAPS45, 8'h43);
      wr(OFS_EYE_SIGNS, 8'h2a);
      @(negedge clock_i);
      chk({8'h0, taps_o.sign1, 2'b0, taps_o.w1}, 16'h9f);
      chk({12'h0, taps_o.signs}, 16'ha);
      chk(taps_o.w, 16'h4321);
      rc(OFS_TAPS45, 8'h43);
      wr(OFS_EQ_POWER, 8'h08);
      @(negedge clock_i);
      chk(taps_o.w, 16'h0);
      wr(OFS_EQ_POWER, 8'h00);
      $display("manual test done");
   endtask : t_manual
   task automatic t_output;
      wr(OFS_SLEW, 8'h04);
      wr(OFS_POLARITY, 8'h80);
      chk({14'h0, slow_edge_o, invert_o}, 16'h3);
      rc(OFS_POLARITY, 8'h80);
      $display("output test done");
   endtask : t_output
   task automatic t_dfe;
      wr(OFS_ADAPT_MODE, 8'h00);
      rc(OFS_OBSERVE_1, 8'h9f);
      wr(OFS_TAP1, rdv);
      rc(OFS_OBSERVE_2, 8'h01);
      rc(OFS_OBSERVE_3, 8'h82);
      rc(OFS_OBSERVE_4, 8'h03);
      rc(OFS_OBSERVE_5, 8'h84);
      wr(OFS_DFE_START, 8'h04);
      wr(OFS_DFE_START, 8'h00);
      @(negedge clock_i);
      chk({15'h0, adapt_busy_o}, 16'h1);
      wait_idle;
      rc(OFS_TAP1, 8'h9f);
      rc(OFS_TAPS23, 8'h21);
      $display("feedback test done");
   endtask : t_dfe
   task automatic t_cdr;
      int n;
      wr(OFS_ADAPT_MODE, 8'h40);
      wr(OFS_CDR_RESET, 8'h0c);
      n = 0;
      while (cdr_reset_o !== 1'b1 && n < 3) begin
         @(negedge clock_i);
         n++;
      end
      chk({15'h0, cdr_reset_o}, 16'h1);
      repeat (2) @(negedge clock_i);
      chk({15'h0, adapt_busy_o}, 16'h1);
      wait_idle;
      $display("recovery test done");
   endtask : t_cdr
   task automatic t_ctle;
      fom_delay = 4'h7;
      wr(OFS_CTLE_START, 8'h01);
      wr(OFS_CTLE_START, 8'h00);
      @(negedge clock_i);
      chk({15'h0, adapt_busy_o}, 16'h1);
      wait_idle;
      chk({12'h0, ctle_boost_o}, 16'h0);
      $display("boost test done");
   endtask : t_ctle
   task automatic t_link;
      int n;
      signal_detect_i = 1'b1;
      n = 0;
      while (cdr_reset_o !== 1'b1 && n < 6) begin
         @(negedge clock_i);
         n++;
      end
      chk({15'h0, cdr_reset_o}, 16'h1);
      @(negedge clock_i);
      chk({15'h0, adapt_busy_o}, 16'h1);
      wait_idle;
      cdr_locked_i = 1'b1;
      wr(OFS_TAPS45, 8'h43);
      repeat (4) @(negedge clock_i);
      cdr_locked_i = 1'b0;
      n = 0;
      while (ctle_boost_o !== 4'h1 && n < 60) begin
         @(negedge clock_i);
         n++;
      end
      chk({12'h0, ctle_boost_o}, 16'h1);
      wait_idle;
      chk({12'h0, ctle_boost_o}, 16'h0);
      $display("link test done");
   endtask : t_link
   initial begin
      rst_n_i = 1'b0;
      reg_wr_i = 1'b0;
      reg_rd_i = 1'b0;
      reg_addr_i = 8'h00;
      reg_wdata_i = 8'h00;
      signal_detect_i = 1'b0;
      cdr_locked_i = 1'b0;
      cdr_eye_range_i = 2'h3;
      fom_delay = 4'h2;
      repeat (16) @(negedge clock_i);
      rst_n_i = 1'b1;
      t_reset;
      t_range;
      t_manual;
      t_output;
      t_dfe;
      t_cdr;
      t_ctle;
      t_link;
      end_sim;
   end
endmodule : tb_top
`default_nettype wire

// File: core/dfe_override_output_ctrl.sv
`default_nettype none
module dfe_override_output_ctrl (
   input  wire logic                       clock_i,          // register clock, 20 MHz
   input  wire logic                       rst_n_i,          // async reset, active low
   input  wire logic                       reg_wr_i,         // register write strobe
   input  wire logic                       reg_rd_i,         // register read strobe
   input  wire logic [7:0]                 reg_addr_i,       // register offset
   input  wire logic [7:0]                 reg_wdata_i,      // write data
   output logic      [7:0]                 reg_rdata_o,      // read data, one cycle later
   input  wire logic                       signal_detect_i,  // analog signal detect, async
   input  wire logic                       cdr_locked_i,     // recovery lock, async
   input  wire logic [1:0]                 cdr_eye_range_i,  // range chosen by recovery fsm
   input  wire logic                       fom_valid_i,      // eye monitor result pulse
   input  wire logic [7:0]                 fom_i,            // figure of merit
   output retimer_ctrl_pkg::tap_set_s      taps_o,           // taps applied to the signal
   output logic                            dfe_power_down_o, // feedback equalizer off
   output logic      [3:0]                 ctle_boost_o,     // linear equalizer boost
   output logic      [1:0]                 eye_range_o,      // effective eye range code
   output logic      [8:0]                 eye_span_mv_o,    // comparator span, +/- mV
   output logic                            eom_power_down_o, // eye monitor power-down
   output logic                            slow_edge_o,      // slow output edges
   output logic                            invert_o,         // output polarity inverted
   output logic                            cdr_reset_o,      // recovery reset pulse
   output logic                            adapt_busy_o      // adaptation running
);
   import retimer_ctrl_pkg::*;

   typedef struct packed {
      logic [7:0]   r0a, r11, r12, r15, r18, r1e, r1f, r20, r21, r23, r24, r2c, r2f, r31;
      logic         dfe_armed;
      logic         ctle_armed;
      adapt_state_e fsm;
      logic         is_dfe;
      logic [2:0]   idx;
      logic [7:0]   best_fom;
      tap_set_s     best_taps;
      tap_set_s     trial_taps;
      tap_set_s     adapted_taps;
      tap_set_s     applied;
      logic [3:0]   best_boost;
      logic [3:0]   trial_boost;
      logic [3:0]   boost;
      logic [3:0]   boost_out;
      logic [1:0]   range;
      logic [7:0]   rdata;
      logic         cdr_reset;
      logic         sd_meta, sd_sync, sd_prev;
      logic         lk_meta, lk_sync, lk_prev;
      logic         taps_dirty;
   } state_s;

   state_s q;
   state_s d;

   function automatic tap_set_s regs_to_taps(input state_s s);
      tap_set_s t;
      t.sign1 = s.r12[BIT_TAP_SIGN];
      t.w1    = s.r12[4:0];
      t.signs = s.r11[3:0];
      t.w[0]  = s.r20[3:0];
      t.w[1]  = s.r20[7:4];
      t.w[2]  = s.r21[3:0];
      t.w[3]  = s.r21[7:4];
      return t;
   endfunction : regs_to_taps

   // one trial per tap: weight raised by one step, saturating
   function automatic tap_set_s bump(input tap_set_s t, input logic [2:0] k);
      tap_set_s r;
      r = t;
      if (k == 3'h1) begin
         if (r.w1 != 5'h1f) r.w1 = r.w1 + 5'h01;
      end else if (k >= 3'h2 && k <= 3'h5) begin
         if (r.w[k-3'h2] != 4'hf) r.w[k-3'h2] = r.w[k-3'h2] + 4'h1;
      end
      return r;
   endfunction : bump

   function automatic logic [7:0] obs(input logic s, input logic [4:0] w);
      return {s, 2'h0, w};
   endfunction : obs

   logic       wr_dfe_start;
   logic       wr_ctle_start;
   logic       start_dfe;
   logic       start_ctle;
   logic       unlocked_arrival;
   logic       lock_lost;
   logic       better;
   logic [2:0] last_idx;

   always_comb begin
      d = q;
      d.cdr_reset = 1'b0;
      // only the second stage reads the first
      d.sd_meta = signal_detect_i;
      d.sd_sync = q.sd_meta;
      d.sd_prev = q.sd_sync;
      d.lk_meta = cdr_locked_i;
      d.lk_sync = q.lk_meta;
      d.lk_prev = q.lk_sync;

      wr_dfe_start  = reg_wr_i && reg_addr_i == OFS_DFE_START;
      wr_ctle_start = reg_wr_i && reg_addr_i == OFS_CTLE_START;
      start_dfe     = 1'b0;
      start_ctle    = 1'b0;

      // host writes, whole byte stored as written
      if (reg_wr_i) begin
         case (reg_addr_i)
            OFS_CDR_RESET:  d.r0a = reg_wdata_i;
            OFS_EYE_SIGNS:  d.r11 = reg_wdata_i;
            OFS_TAP1:       d.r12 = reg_wdata_i;
            OFS_MANUAL:     d.r15 = reg_wdata_i;
            OFS_SLEW:       d.r18 = reg_wdata_i;
            OFS_EQ_POWER:   d.r1e = reg_wdata_i;
            OFS_POLARITY:   d.r1f = reg_wdata_i;
            OFS_TAPS23:     d.r20 = reg_wdata_i;
            OFS_TAPS45:     d.r21 = reg_wdata_i;
            OFS_OVERRIDE:   d.r23 = reg_wdata_i;
            OFS_DFE_START:  d.r24 = reg_wdata_i;
            OFS_RANGE_SRC:  d.r2c = reg_wdata_i;
            OFS_CTLE_START: d.r2f = reg_wdata_i;
            OFS_ADAPT_MODE: d.r31 = reg_wdata_i;
            default:        d.r0a = q.r0a;
         endcase
      end

      // recovery reset: host write of its bits, or signal arriving unlocked
      unlocked_arrival = q.sd_sync && !q.sd_prev && !q.lk_sync;
      if ((reg_wr_i && reg_addr_i == OFS_CDR_RESET
           && reg_wdata_i[BIT_CDR_RST_HI:BIT_CDR_RST_LO] != 2'h0)
          || unlocked_arrival) begin
         d.cdr_reset = 1'b1;
      end

      // start bits fire on the clear that follows a set
      if (wr_dfe_start) begin
         if (reg_wdata_i[BIT_DFE_START]) begin
            d.dfe_armed = 1'b1;
         end else if (q.dfe_armed) begin
            d.dfe_armed = 1'b0;
            start_dfe   = 1'b1;
         end
      end
      if (wr_ctle_start) begin
         if (reg_wdata_i[BIT_CTLE_START]) begin
            d.ctle_armed = 1'b1;
         end else if (q.ctle_armed) begin
            d.ctle_armed = 1'b0;
            start_ctle   = 1'b1;
         end
      end
      if (q.cdr_reset && q.r31[BIT_MODE_LO+1]) begin
         start_dfe = 1'b1;
      end

      // tap edits that later cost lock re-adapt the boost; a new edit beats the clear
      lock_lost = q.lk_prev && !q.lk_sync;
      if (lock_lost && q.taps_dirty) begin
         start_ctle   = 1'b1;
         d.taps_dirty = 1'b0;
      end
      if (reg_wr_i && (reg_addr_i == OFS_TAP1 || reg_addr_i == OFS_TAPS23
                       || reg_addr_i == OFS_TAPS45 || reg_addr_i == OFS_EYE_SIGNS)) begin
         d.taps_dirty = 1'b1;
      end

      last_idx = q.is_dfe ? DFE_LAST_IDX : CTLE_LAST_IDX;
      better   = q.idx == 3'h0 || fom_i > q.best_fom;

      case (q.fsm)
         ST_IDLE: begin
            // a trigger while busy is dropped; idle picks dfe first
            if (start_dfe) begin
               d.is_dfe     = 1'b1;
               d.idx        = 3'h0;
               d.trial_taps = regs_to_taps(q);
               d.fsm        = ST_EVAL;
            end else if (start_ctle) begin
               d.is_dfe      = 1'b0;
               d.idx         = 3'h0;
               d.trial_boost = q.boost;
               d.fsm         = ST_EVAL;
            end
         end
         ST_EVAL: begin
            if (fom_valid_i) begin
               // the start point is scored first, so a loser never replaces it
               if (better) begin
                  d.best_fom   = fom_i;
                  d.best_taps  = q.trial_taps;
                  d.best_boost = q.trial_boost;
               end
               if (q.idx == last_idx) begin
                  d.fsm = ST_DONE;
               end else begin
                  d.idx = q.idx + 3'h1;
                  d.fsm = ST_NEXT;
               end
            end
         end
         ST_NEXT: begin
            if (q.is_dfe) begin
               d.trial_taps = bump(q.best_taps, q.idx);
            end else if (q.idx == 3'h1) begin
               d.trial_boost = (q.best_boost == 4'hf) ? q.best_boost : q.best_boost + 4'h1;
            end else begin
               d.trial_boost = (q.best_boost == 4'h0) ? q.best_boost : q.best_boost - 4'h1;
            end
            d.fsm = ST_EVAL;
         end
         ST_DONE: begin
            if (q.is_dfe) begin
               // result goes back to the tap registers, over any host write now
               d.adapted_taps = q.best_taps;
               d.r12 = {q.best_taps.sign1, q.r12[6:5], q.best_taps.w1};
               d.r11 = {q.r11[7:4], q.best_taps.signs};
               d.r20 = {q.best_taps.w[1], q.best_taps.w[0]};
               d.r21 = {q.best_taps.w[3], q.best_taps.w[2]};
            end else begin
               d.boost = q.best_boost;
            end
            d.fsm = ST_IDLE;
         end
         default: d.fsm = ST_IDLE;
      endcase

      // applied taps
      if (q.r1e[BIT_EQ_PD]) begin
         d.applied = '0;
      end else if (q.fsm != ST_IDLE && q.is_dfe) begin
         d.applied = q.trial_taps;
      end else if (q.r15[BIT_MANUAL_EN] && q.r23[BIT_OVERRIDE]) begin
         d.applied = regs_to_taps(q);
      end else begin
         d.applied = q.adapted_taps;
      end
      d.boost_out = (q.fsm != ST_IDLE && !q.is_dfe) ? q.trial_boost : q.boost;
      d.range = q.r2c[BIT_RANGE_AUTO] ? cdr_eye_range_i
                                      : q.r11[BIT_EYE_RANGE_LO+1:BIT_EYE_RANGE_LO];

      // readback
      if (reg_rd_i) begin
         case (reg_addr_i)
            OFS_CDR_RESET:  d.rdata = q.r0a;
            OFS_EYE_SIGNS:  d.rdata = q.r11;
            OFS_TAP1:       d.rdata = q.r12;
            OFS_MANUAL:     d.rdata = q.r15;
            OFS_SLEW:       d.rdata = q.r18;
            OFS_EQ_POWER:   d.rdata = q.r1e;
            OFS_POLARITY:   d.rdata = q.r1f;
            OFS_TAPS23:     d.rdata = q.r20;
            OFS_TAPS45:     d.rdata = q.r21;
            OFS_OVERRIDE:   d.rdata = q.r23;
            OFS_DFE_START:  d.rdata = q.r24;
            OFS_RANGE_SRC:  d.rdata = q.r2c;
            OFS_CTLE_START: d.rdata = q.r2f;
            OFS_ADAPT_MODE: d.rdata = q.r31;
            OFS_OBSERVE_1:  d.rdata = obs(q.applied.sign1, q.applied.w1);
            OFS_OBSERVE_2:  d.rdata = obs(q.applied.signs[0], {1'b0, q.applied.w[0]});
            OFS_OBSERVE_3:  d.rdata = obs(q.applied.signs[1], {1'b0, q.applied.w[1]});
            OFS_OBSERVE_4:  d.rdata = obs(q.applied.signs[2], {1'b0, q.applied.w[2]});
            OFS_OBSERVE_5:  d.rdata = obs(q.applied.signs[3], {1'b0, q.applied.w[3]});
            default:        d.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q     <= '0;
         q.r11 <= RST_EYE_SIGNS;
         q.r1e <= RST_EQ_POWER;
         q.r23 <= RST_OVERRIDE;
         q.r2c <= RST_RANGE_SRC;
         q.r31 <= RST_ADAPT_MODE;
         q.fsm <= ST_IDLE;
      end else begin
         q <= d;
      end
   end

   assign reg_rdata_o      = q.rdata;
   assign taps_o           = q.applied;
   assign dfe_power_down_o = q.r1e[BIT_EQ_PD];
   assign ctle_boost_o     = q.boost_out;
   assign eye_range_o      = q.range;
   assign eye_span_mv_o    = EYE_STEP_MV * ({7'h00, q.range} + 9'h001);
   assign eom_power_down_o = q.r11[BIT_EOM_PD];
   assign slow_edge_o      = q.r18[BIT_SLOW_EDGE];
   assign invert_o         = q.r1f[BIT_INVERT];
   assign cdr_reset_o      = q.cdr_reset;
   assign adapt_busy_o     = q.fsm != ST_IDLE;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_set_dfe;
      reg_wr_i && reg_addr_i == OFS_DFE_START && reg_wdata_i[BIT_DFE_START];
   endsequence
   sequence s_clr_dfe;
      reg_wr_i && reg_addr_i == OFS_DFE_START && !reg_wdata_i[BIT_DFE_START];
   endsequence
   sequence s_set_ctle;
      reg_wr_i && reg_addr_i == OFS_CTLE_START && reg_wdata_i[BIT_CTLE_START];
   endsequence
   sequence s_clr_ctle;
      reg_wr_i && reg_addr_i == OFS_CTLE_START && !reg_wdata_i[BIT_CTLE_START];
   endsequence

   a_span_code: assert property (
      eye_span_mv_o == 9'd100 * ({7'h00, eye_range_o} + 9'd1))
      else $error("eye span does not match range code");
   a_range_host: assert property (
      !q.r2c[BIT_RANGE_AUTO] |=> eye_range_o == $past(q.r11[7:6]))
      else $error("eye range ignores host field");
   a_pd_blocks: assert property (
      q.r1e[BIT_EQ_PD] |=> taps_o == '0)
      else $error("taps reach signal while powered down");
   a_manual_taps: assert property (
      !q.r1e[BIT_EQ_PD] && q.fsm == ST_IDLE && q.r15[7] && q.r23[6]
      |=> taps_o.w1 == $past(q.r12[4:0]) && taps_o.sign1 == $past(q.r12[7]))
      else $error("manual first tap not applied");
   a_dfe_start: assert property (
      q.fsm == ST_IDLE && !q.dfe_armed ##0 s_set_dfe ##1 (!reg_wr_i)[*1]
      ##1 (s_clr_dfe and (q.fsm == ST_IDLE))
      |=> q.fsm == ST_EVAL && q.is_dfe)
      else $error("dfe adaptation did not start on set then clear");
   a_ctle_start: assert property (
      q.fsm == ST_IDLE && !q.cdr_reset && !(q.lk_prev && !q.lk_sync) ##0 s_set_ctle
      ##1 (!reg_wr_i)[*1]
      ##1 (s_clr_ctle and (q.fsm == ST_IDLE) and !q.cdr_reset)
      |=> q.fsm == ST_EVAL && !q.is_dfe)
      else $error("ctle adaptation did not start on set then clear");
   a_cdr_write: assert property (
      reg_wr_i && reg_addr_i == OFS_CDR_RESET && reg_wdata_i[3:2] != 2'h0
      |=> cdr_reset_o ##1 !cdr_reset_o || $past(reg_wr_i))
      else $error("recovery reset pulse missing");
   a_mode_readapt: assert property (
      cdr_reset_o && q.r31[6] && q.fsm == ST_IDLE |=> q.fsm == ST_EVAL && q.is_dfe)
      else $error("mode two or three did not re-adapt taps");
   a_keep_start: assert property (
      q.fsm == ST_EVAL && fom_valid_i && q.idx != 3'h0 && fom_i <= q.best_fom
      |=> $stable(q.best_taps) && $stable(q.best_fom))
      else $error("worse trial replaced best taps");
   a_out_ctrl: assert property (
      reg_wr_i && reg_addr_i == OFS_POLARITY |=> invert_o == $past(reg_wdata_i[7]))
      else $error("polarity write not applied");
   a_slew_write: assert property (
      reg_wr_i && reg_addr_i == OFS_SLEW |=> slow_edge_o == $past(reg_wdata_i[2]))
      else $error("slew write not applied");
   a_lock_readapt: assert property (
      lock_lost && q.taps_dirty && q.fsm == ST_IDLE && !start_dfe
      |=> q.fsm == ST_EVAL && !q.is_dfe)
      else $error("lock loss after tap edit did not re-adapt boost");
endmodule : dfe_override_output_ctrl
`default_nettype wire

// File: core/retimer_ctrl_pkg.sv
`default_nettype none
package retimer_ctrl_pkg;
   // register offsets
   localparam logic [7:0] OFS_CDR_RESET   = 8'h0a;
   localparam logic [7:0] OFS_EYE_SIGNS   = 8'h11;
   localparam logic [7:0] OFS_TAP1        = 8'h12;
   localparam logic [7:0] OFS_MANUAL      = 8'h15;
   localparam logic [7:0] OFS_SLEW        = 8'h18;
   localparam logic [7:0] OFS_EQ_POWER    = 8'h1e;
   localparam logic [7:0] OFS_POLARITY    = 8'h1f;
   localparam logic [7:0] OFS_TAPS23      = 8'h20;
   localparam logic [7:0] OFS_TAPS45      = 8'h21;
   localparam logic [7:0] OFS_OVERRIDE    = 8'h23;
   localparam logic [7:0] OFS_DFE_START   = 8'h24;
   localparam logic [7:0] OFS_RANGE_SRC   = 8'h2c;
   localparam logic [7:0] OFS_CTLE_START  = 8'h2f;
   localparam logic [7:0] OFS_ADAPT_MODE  = 8'h31;
   localparam logic [7:0] OFS_OBSERVE_1   = 8'h71;
   localparam logic [7:0] OFS_OBSERVE_2   = 8'h72;
   localparam logic [7:0] OFS_OBSERVE_3   = 8'h73;
   localparam logic [7:0] OFS_OBSERVE_4   = 8'h74;
   localparam logic [7:0] OFS_OBSERVE_5   = 8'h75;
   // field positions
   localparam int BIT_CDR_RST_LO   = 2;
   localparam int BIT_CDR_RST_HI   = 3;
   localparam int BIT_EYE_RANGE_LO = 6;
   localparam int BIT_EOM_PD       = 5;
   localparam int BIT_TAP_SIGN     = 7;
   localparam int BIT_MANUAL_EN    = 7;
   localparam int BIT_SLOW_EDGE    = 2;
   localparam int BIT_EQ_PD        = 3;
   localparam int BIT_INVERT       = 7;
   localparam int BIT_OVERRIDE     = 6;
   localparam int BIT_DFE_START    = 2;
   localparam int BIT_RANGE_AUTO   = 6;
   localparam int BIT_CTLE_START   = 0;
   localparam int BIT_MODE_LO      = 5;
   // reset values
   localparam logic [7:0] RST_EYE_SIGNS  = 8'h20;
   localparam logic [7:0] RST_EQ_POWER   = 8'h08;
   localparam logic [7:0] RST_OVERRIDE   = 8'h40;
   localparam logic [7:0] RST_RANGE_SRC  = 8'h40;
   localparam logic [7:0] RST_ADAPT_MODE = 8'h20;
   // adaptation sweep and eye span step
   localparam logic [2:0] DFE_LAST_IDX  = 3'h5;
   localparam logic [2:0] CTLE_LAST_IDX = 3'h2;
   localparam logic [8:0] EYE_STEP_MV   = 9'h064;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EVAL = 2'b01,
      ST_NEXT = 2'b10,
      ST_DONE = 2'b11
   } adapt_state_e;

   typedef struct packed {
      logic            sign1;
      logic [4:0]      w1;
      logic [3:0]      signs;   // taps 2..5
      logic [3:0][3:0] w;       // taps 2..5
   } tap_set_s;

endpackage : retimer_ctrl_pkg
`default_nettype wire
